// [hw/msd_pkg.sv]
package msd_pkg;

  // Internal data space layout.
  localparam int IDATA_BYTES = 256;
  localparam int UPPER_BASE = 128;
  localparam int BANK_BYTES = 32;
  localparam int BANK_COUNT = 4;
  localparam int BITAREA_BASE = 32;
  localparam int BITAREA_BYTES = 16;
  localparam int PSW_BANK_LSB = 3;

  // Program space layout.
  localparam int SECTOR_BYTES = 512;
  localparam int FLASH_64K = 65536;
  localparam int FLASH_32K = 32768;
  localparam logic [15:0] RESERVED_BASE = 16'hFC00;
  localparam logic [15:0] RESERVED_LAST = 16'hFFFF;
  localparam logic [7:0] RESERVED_READ = 8'hFF;

  // External-space RAM and endpoint buffer sizes.
  localparam int EXT_RAM_64K_BYTES = 4096;
  localparam int EXT_RAM_32K_BYTES = 2048;
  localparam int EPBUF_BYTES = 1024;
  localparam logic [9:0] EP0_BASE = 10'h000;
  localparam logic [9:0] EP1_BASE = 10'h040;
  localparam logic [9:0] EP2_BASE = 10'h0C0;
  localparam logic [9:0] EP3_BASE = 10'h200;
  localparam int EP3_BYTES = 512;

  // Memory spaces that a core access can address.
  typedef enum logic [2:0] {
    SPACE_IDATA = 3'h0,
    SPACE_CODE = 3'h1,
    SPACE_XDATA = 3'h3,
    SPACE_EPBUF = 3'h2
  } msd_space_type;

  // One access from the processor core.
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic bit_access;
    msd_space_type space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msd_req_type;

  // Result of an access, returned one cycle later.
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic reserved_hit;
    logic range_error;
  } msd_rsp_type;

endpackage

// [hw/msd_decoder.sv]
// Functional notes
// - Internal data RAM holds 256 bytes addressable by the core.
// - Indirect upper-half addresses reach the upper 128 RAM bytes.
// - Direct upper-half addresses go to the special function register space.
// - Lower 128 bytes answer identically under direct and indirect addressing.
// - Lowest 32 bytes form four banks of working registers.
// - The 16 bytes above the banks are byte and bit addressable.
// - Flash of 64k or 32k is erased in system in 512-byte sectors.
// - External-space RAM is 4k on 64k parts and 2k on 32k parts.
// - On 64k parts 0xFC00 to 0xFFFF is reserved program space.
// - A separate 1k endpoint buffer RAM exists beside external-space RAM.
// - Endpoint buffer splits among endpoints 0-3; endpoint 3 gets 512 bytes.
module msd_decoder
  import msd_pkg::*;
#(
  parameter bit BIG_FLASH = 1'b1
)
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Core access port.
  input wire msd_req_type req_in,
  input wire logic erase_in,
  input wire logic [1:0] bank_sel_in,
  input wire logic [2:0] reg_num_in,
  // Special function register space port.
  output logic special_function_register_space_sel_out,
  output logic [6:0] special_function_register_space_addr_out,
  input wire logic [7:0] special_function_register_space_rdata_in,
  // Access answer and status.
  output msd_rsp_type rsp_out,
  output logic [4:0] bank_reg_addr_out,
  output logic erase_busy_out
);

  localparam int FLASH_BYTES = BIG_FLASH ? FLASH_64K : FLASH_32K;
  localparam int EXT_RAM_BYTES = BIG_FLASH ? EXT_RAM_64K_BYTES : EXT_RAM_32K_BYTES;
  localparam int SECTOR_COUNT = FLASH_BYTES / SECTOR_BYTES;

  logic [7:0] idata [IDATA_BYTES];
  logic [7:0] flash [FLASH_BYTES];
  logic [7:0] ext_ram [EXT_RAM_BYTES];
  logic [7:0] epbuf [EPBUF_BYTES];

  // Bit address: 0x00-0x7F map to bits of bytes 0x20-0x2F.
  function automatic logic [7:0] bit_byte(input logic [7:0] bitaddr);
    bit_byte = 8'(BITAREA_BASE) + {4'h0, bitaddr[6:3]};
  endfunction

  // Endpoint slot that owns a buffer offset; the top half belongs to endpoint 3.
  function automatic logic [1:0] ep_slot_of(input logic [9:0] offset);
    if (offset >= EP3_BASE)
      ep_slot_of = 2'h3;
    else if (offset >= EP2_BASE)
      ep_slot_of = 2'h2;
    else if (offset >= EP1_BASE)
      ep_slot_of = 2'h1;
    else
      ep_slot_of = 2'h0;
  endfunction

  // Internal data space: the upper half splits by addressing mode, lower-half bit addresses fold into the bit area.
  wire logic is_idata = req_in.valid && req_in.space == SPACE_IDATA;
  wire logic upper = req_in.addr[7:0] >= 8'(UPPER_BASE);
  wire logic bit_in_ram = req_in.bit_access && !upper;
  wire logic [7:0] idata_addr = bit_in_ram ? bit_byte(req_in.addr[7:0]) : req_in.addr[7:0];
  wire logic to_func_reg = is_idata && upper && !req_in.indirect && !bit_in_ram;
  wire logic to_ram = is_idata && !to_func_reg;

  // Program space: the top region of the large part is never programmed or erased.
  wire logic is_code = req_in.valid && req_in.space == SPACE_CODE;
  wire logic in_reserved = BIG_FLASH && req_in.addr >= RESERVED_BASE && req_in.addr <= RESERVED_LAST;
  wire logic code_ok = is_code && 32'(req_in.addr) < FLASH_BYTES && !in_reserved;
  wire logic flash_erase = code_ok && erase_in;
  wire logic flash_program = code_ok && req_in.write && !erase_in;
  wire logic [6:0] sector_idx = req_in.addr[15:9];

  // External-space RAM and endpoint buffer: anything past the end is refused.
  wire logic is_ext_ram = req_in.valid && req_in.space == SPACE_XDATA;
  wire logic ext_ram_ok = is_ext_ram && 32'(req_in.addr) < EXT_RAM_BYTES;
  wire logic [11:0] ext_ram_idx = req_in.addr[11:0];
  wire logic is_ep = req_in.valid && req_in.space == SPACE_EPBUF;
  wire logic ep_ok = is_ep && 32'(req_in.addr) < EPBUF_BYTES;
  wire logic [1:0] ep_slot = ep_slot_of(req_in.addr[9:0]);
  wire logic bad = (is_code && !code_ok && !in_reserved) || (is_ext_ram && !ext_ram_ok) || (is_ep && !ep_ok);

  // Byte read from internal RAM and the byte that a write leaves behind.
  wire logic [7:0] rbyte = idata[idata_addr];
  wire logic [7:0] bit_mask = 8'h01 << req_in.addr[2:0];
  wire logic [7:0] bit_merged = req_in.wdata[0] ? rbyte | bit_mask : rbyte & ~bit_mask;
  wire logic [7:0] wbyte = bit_in_ram ? bit_merged : req_in.wdata;

  // Working register address from bank select and register number.
  assign bank_reg_addr_out = {bank_sel_in, reg_num_in};
  // The register space is selected combinationally and answers within the same cycle.
  assign special_function_register_space_sel_out = to_func_reg;
  assign special_function_register_space_addr_out = req_in.addr[6:0];
  // Erase finishes in the taking cycle, so the busy flag never rises.
  assign erase_busy_out = 1'b0;

  // Sector erase wipes one 512-byte sector to erased state; programming only clears bits.
  always_ff @(posedge clock_in)
  begin
    if (flash_erase)
    begin
      for (int i = 0; i < SECTOR_BYTES; i++)
        flash[{sector_idx, 9'h000} + 16'(i)] <= 8'hFF;
    end
    else if (flash_program)
      flash[req_in.addr] <= flash[req_in.addr] & req_in.wdata;
  end

  // Data memory writes.
  always_ff @(posedge clock_in)
  begin
    if (to_ram && req_in.write)
      idata[idata_addr] <= wbyte;
    if (ext_ram_ok && req_in.write)
      ext_ram[ext_ram_idx] <= req_in.wdata;
    if (ep_ok && req_in.write)
      epbuf[req_in.addr[9:0]] <= req_in.wdata;
  end

  // Read answer register.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rsp_out <= '0;
    else
    begin
      rsp_out.valid <= req_in.valid;
      rsp_out.reserved_hit <= is_code && in_reserved;
      rsp_out.range_error <= bad;
      if (to_func_reg)
        rsp_out.rdata <= special_function_register_space_rdata_in;
      else if (to_ram)
        rsp_out.rdata <= bit_in_ram ? {7'h00, rbyte[req_in.addr[2:0]]} : rbyte;
      else if (code_ok)
        rsp_out.rdata <= flash[req_in.addr];
      else if (ext_ram_ok)
        rsp_out.rdata <= ext_ram[ext_ram_idx];
      else if (ep_ok)
        rsp_out.rdata <= epbuf[req_in.addr[9:0]];
      else
        rsp_out.rdata <= RESERVED_READ;
    end
  end

  // Endpoint 3 owns exactly the top 512 bytes of the buffer.
  a_ep3_slot_size : assert property (@(posedge clock_in) disable iff (!nrst_in)
    ep_ok |-> (ep_slot == 2'h3) == (32'(req_in.addr) >= EPBUF_BYTES - EP3_BYTES))
    else $error("endpoint 3 slot size wrong");

  // Only direct upper-half accesses may select the register space.
  a_func_reg_direct : assert property (@(posedge clock_in) disable iff (!nrst_in)
    special_function_register_space_sel_out |-> is_idata && !req_in.indirect && upper)
    else $error("indirect access reached register space");

  // The register space data is handed back in the cycle after selection.
  a_func_reg_data : assert property (@(posedge clock_in) disable iff (!nrst_in)
    to_func_reg |=> rsp_out.rdata == $past(special_function_register_space_rdata_in))
    else $error("register space data lost");

  // Indirect accesses always stay in RAM, upper half included.
  a_upper_indirect : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_idata && req_in.indirect |-> to_ram && !special_function_register_space_sel_out)
    else $error("indirect upper not ram");

  // Lower-half byte accesses reach the same RAM byte in either addressing mode.
  a_lower_same : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_idata && !upper && !req_in.bit_access |-> to_ram && idata_addr == req_in.addr[7:0])
    else $error("lower half not ram");

  // A byte write to RAM is stored at the addressed byte.
  a_ram_byte_write : assert property (@(posedge clock_in) disable iff (!nrst_in)
    to_ram && req_in.write && !bit_in_ram |=> idata[$past(idata_addr)] == $past(req_in.wdata))
    else $error("ram byte not stored");

  // Working register addresses stay inside the four banks and follow the bank field.
  a_bank_address : assert property (@(posedge clock_in) disable iff (!nrst_in)
    32'(bank_reg_addr_out) < BANK_BYTES && 32'(bank_reg_addr_out[4:3]) < BANK_COUNT && bank_reg_addr_out[4:3] == bank_sel_in)
    else $error("bank address wrong");

  // Bit addresses below 0x80 always land in the bit-addressable bytes.
  a_bit_area_map : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_idata && bit_in_ram |-> idata_addr >= 8'(BITAREA_BASE) && idata_addr < 8'(BITAREA_BASE + BITAREA_BYTES))
    else $error("bit access outside area");

  // A bit access below 0x80 answers with the bit alone in the lowest position.
  a_bit_read_lsb : assert property (@(posedge clock_in) disable iff (!nrst_in)
    to_ram && bit_in_ram |=> rsp_out.rdata[7:1] == 7'h00)
    else $error("bit answer not isolated");

  // Reserved reads answer the fixed value and flag the hit.
  a_reserved_fixed : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_code && in_reserved |=> rsp_out.rdata == RESERVED_READ && rsp_out.reserved_hit)
    else $error("reserved read not fixed");

  // The reserved region never reaches the flash write or erase enables.
  a_reserved_protect : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_code && in_reserved |-> !flash_erase && !flash_program)
    else $error("reserved region writable");

  // An erased sector reads as erased at the address that named it.
  a_sector_erased : assert property (@(posedge clock_in) disable iff (!nrst_in)
    flash_erase |=> flash[$past(req_in.addr)] == 8'hFF)
    else $error("sector not erased");

  // Erase only names sectors that exist in this flash size.
  a_sector_index : assert property (@(posedge clock_in) disable iff (!nrst_in)
    flash_erase |-> 32'(sector_idx) < SECTOR_COUNT)
    else $error("sector index out of range");

  // Program addresses past the flash end are refused.
  a_code_range : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_code && !in_reserved |=> rsp_out.range_error == (32'($past(req_in.addr)) >= FLASH_BYTES))
    else $error("program range flag wrong");

  // External-space RAM addresses past its size are refused.
  a_ext_ram_range : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_ext_ram |=> rsp_out.range_error == ($past(req_in.addr) >= 16'(EXT_RAM_BYTES)))
    else $error("external ram out of range");

  // Endpoint buffer addresses past its size are refused.
  a_ep_range : assert property (@(posedge clock_in) disable iff (!nrst_in)
    is_ep |=> rsp_out.range_error == ($past(req_in.addr) >= 16'(EPBUF_BYTES)))
    else $error("endpoint buffer out of range");

endmodule

// [testbench/msd_sfr_model.sv]
module msd_func_reg_model
(
  // Register space select and address.
  input wire logic space_sel_in,
  input wire logic [6:0] space_addr_in,
  // Register read data.
  output logic [7:0] space_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each register reads as its address mixed with a pattern; unselected reads are inverted.
  assign space_rdata_out = space_sel_in ? ({1'b1, space_addr_in} ^ 8'h3C) : ~({1'b1, space_addr_in} ^ 8'h3C);
endmodule

// [testbench/tb_msd_decoder.sv]
module tb_msd_decoder;
  import msd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, nrst_in, erase_in, reg_space_sel, erase_busy_out, sel;
  msd_req_type req_in;
  msd_rsp_type rsp_out;
  logic [1:0] bank_sel_in;
  logic [2:0] reg_num_in;
  logic [6:0] reg_space_addr;
  logic [7:0] reg_space_rdata, a, d;
  logic [4:0] bank_reg_addr_out;
  int err_count, n_tests, cycles, seed = 38;
  msd_decoder u_msd_decoder (.clock_in(clock_in), .nrst_in(nrst_in), .req_in(req_in), .erase_in(erase_in),
    .bank_sel_in(bank_sel_in), .reg_num_in(reg_num_in), .special_function_register_space_sel_out(reg_space_sel),
    .special_function_register_space_addr_out(reg_space_addr),
    .special_function_register_space_rdata_in(reg_space_rdata), .rsp_out(rsp_out),
    .bank_reg_addr_out(bank_reg_addr_out), .erase_busy_out(erase_busy_out));
  msd_func_reg_model u_msd_func_reg_model (.space_sel_in(reg_space_sel), .space_addr_in(reg_space_addr),
    .space_rdata_out(reg_space_rdata));
  // Free-running clock and a cycle ceiling against hangs.
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  // One access: held over its taking edge, then the answer is checked for validity.
  task automatic acc(input logic w, ind, bt, msd_space_type sp, logic [15:0] ad, logic [7:0] wd, logic er);
    @(posedge clock_in);
    #1 req_in = '{1'b1, w, ind, bt, sp, ad, wd};
    erase_in = er;
    #1 sel = reg_space_sel;
    @(posedge clock_in);
    #1 req_in.valid = 1'b0;
    erase_in = 1'b0;
    chk1(rsp_out.valid, 1'b1);
  endtask
  function automatic logic [7:0] func_reg_exp(input logic [7:0] x);
    return {1'b1, x[6:0]} ^ 8'h3C;
  endfunction
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Random internal RAM traffic, then the program, external and buffer corner cases.
  initial
  begin
    nrst_in = 1'b0;
    req_in = '0;
    erase_in = 1'b0;
    bank_sel_in = 2'h0;
    reg_num_in = 3'h0;
    repeat (2) @(posedge clock_in);
    #1 nrst_in = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      a = $random(seed);
      d = $random(seed);
      acc(1'b1, a[7], 1'b0, SPACE_IDATA, {8'h00, a}, d, 1'b0);
      acc(1'b0, 1'b1, 1'b0, SPACE_IDATA, {8'h00, a}, 8'h00, 1'b0);
      chk8(rsp_out.rdata, d);
      acc(1'b0, 1'b0, 1'b0, SPACE_IDATA, {8'h00, a}, 8'h00, 1'b0);
      chk8(rsp_out.rdata, a[7] ? func_reg_exp(a) : d);
      chk1(sel, a[7]);
      bank_sel_in = a[1:0];
      reg_num_in = d[2:0];
      #1 chk8({3'h0, bank_reg_addr_out}, {3'h0, a[1:0], d[2:0]});
    end
    acc(1'b1, 1'b0, 1'b0, SPACE_IDATA, 16'h0021, 8'h00, 1'b0);
    acc(1'b1, 1'b0, 1'b1, SPACE_IDATA, 16'h000D, 8'h01, 1'b0);
    acc(1'b0, 1'b0, 1'b0, SPACE_IDATA, 16'h0021, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'h20);
    acc(1'b0, 1'b0, 1'b1, SPACE_IDATA, 16'h000D, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'h01);
    acc(1'b0, 1'b0, 1'b1, SPACE_IDATA, 16'h000C, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'h00);
    acc(1'b0, 1'b0, 1'b0, SPACE_CODE, 16'hFBFF, 8'h00, 1'b1);
    chk1(erase_busy_out, 1'b0);
    acc(1'b1, 1'b0, 1'b0, SPACE_CODE, 16'hFA00, 8'h0F, 1'b0);
    acc(1'b1, 1'b0, 1'b0, SPACE_CODE, 16'hFA00, 8'hF3, 1'b0);
    acc(1'b0, 1'b0, 1'b0, SPACE_CODE, 16'hFA00, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'h03);
    acc(1'b0, 1'b0, 1'b0, SPACE_CODE, 16'hFA00, 8'h00, 1'b1);
    acc(1'b0, 1'b0, 1'b0, SPACE_CODE, 16'hFBFF, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'hFF);
    chk1(rsp_out.reserved_hit, 1'b0);
    acc(1'b1, 1'b0, 1'b0, SPACE_CODE, 16'hFC00, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 1'b0, SPACE_CODE, 16'hFC00, 8'h00, 1'b0);
    chk8(rsp_out.rdata, 8'hFF);
    chk1(rsp_out.reserved_hit, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, 1'b0, 1'b0, k ? SPACE_EPBUF : SPACE_XDATA, k ? 16'h03FF : 16'h0FFF, 8'hA5, 1'b0);
      acc(1'b0, 1'b0, 1'b0, k ? SPACE_EPBUF : SPACE_XDATA, k ? 16'h03FF : 16'h0FFF, 8'h00, 1'b0);
      chk8(rsp_out.rdata, 8'hA5);
      chk1(rsp_out.range_error, 1'b0);
      acc(1'b0, 1'b0, 1'b0, k ? SPACE_EPBUF : SPACE_XDATA, k ? 16'h0400 : 16'h1000, 8'h00, 1'b0);
      chk1(rsp_out.range_error, 1'b1);
    end
    complete_run();
  end
endmodule
